// *** vic_ctrl.sv ***
// Vectored interrupt controller with APB registers, edge inputs and nesting status.
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////
// How it works
// [RQ1] Ten request flags and ten matching enable flags, eight vectored and two test sources.
// [RQ2] A source event sets its request flag; acceptance clears it, except the shared vector with both its sources enabled.
// [RQ3] Request and enable both set drive that vector's request line, also used for wake.
// [RQ4] A request flag written to one by software interrupts like a hardware request.
// [RQ5] Reset clears every request and enable flag, so nothing can interrupt.
// [RQ6] Pin four sets on either edge; peripheral pulses set the internal flags.
// [RQ7] Edge select bit zero picks rising, one picks falling, for pins zero and one.
// [RQ8] The test pin two sets its flag on rising edges only.
// [RQ9] Pin zero passes a sampled filter needing two agreeing samples before it changes.
// [RQ10] Bit three of the pin zero select picks CPU clock or divided oscillator sampling.
// [RQ11] Reset clears both edge select registers, giving rising edge detection.
// [RQ12] In standby the pin zero sampler stops, so that pin cannot be detected.
// [RQ13] Software disables interrupts, changes edge select, clears the flag, then re-enables.
// [RQ14] Low three bits of the priority register name the one high-order vector.
// [RQ15] Bit three is the master enable; enable sets it, disable clears it, reset zeroes all.
// [RQ16] Software clears the master enable before changing the high-order selection.
// [RQ17] Status 00 takes all, 01 only high-order, 10 none; acceptance steps it up.
// [RQ18] The status goes out with the status word on acceptance; return restores it.
// [RQ19] Software may zero the status for deeper nesting after disabling interrupts.
// [RQ20] With one shared source enabled it behaves normally and is cleared on acceptance.
// [RQ21] With both shared sources enabled the request is their AND and neither is cleared.
// [RQ22] The vector word gives the service start address and both bank enable flags.
// [RQ23] Simultaneous requests resolve by fixed priority one to seven, vectors two to fourteen.
// [RQ24] Test sources obey their enables but never raise a vectored interrupt.
module vic_ctrl #(
  parameter int FILTER_STAGES = 2
) (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [vic_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // External pins and peripheral events.
  input  wire logic                          filtered_ext_pin,
  input  wire logic                          second_ext_pin,
  input  wire logic                          test_ext_pin,
  input  wire logic                          dual_edge_ext_pin,
  input  wire logic                          fx_div64_tick,
  input  wire logic                          standby,
  input  wire logic                          basic_timer_event,
  input  wire logic                          serial_done_event,
  input  wire logic                          timer_match_event,
  input  wire logic                          pulse_gen_event,
  input  wire logic                          key_scan_event,
  input  wire logic                          clock_timer_event,
  // CPU core side.
  input  wire logic                          enable_instr,
  input  wire logic                          disable_instr,
  input  wire logic                          cpu_accept,
  input  wire logic [vic_pkg::VW_W-1:0]      vector_word,
  input  wire logic                          return_from_interrupt,
  input  wire logic [1:0]                    restore_status,
  output logic                               int_request,
  output logic [2:0]                         vector_index,
  output logic [vic_pkg::ADDR_W-1:0]         vector_addr,
  output logic [vic_pkg::VEC_N:1]            vectored_request_line,
  output logic                               standby_wake,
  output logic [1:0]                         nest_status,
  output logic [vic_pkg::START_W-1:0]        service_start,
  output logic                               memory_bank_enable,
  output logic                               register_bank_enable
);

  logic [vic_pkg::SRC_N-1:0]   req_q, req_d, en_q, set_evt, clr_acc;
  logic [3:0]                  pin0_sel_q, pin1_sel_q, prio_q;
  logic [1:0]                  nest_q;
  logic [vic_pkg::VEC_N:1]     vrq, allowed, cand, high_mask;
  logic                        both_shared, pend;
  logic [2:0]                  pend_idx;
  logic                        pin0_tick, pin0_clean, pin0_evt, pin1_evt, pin2_evt, pin4_evt;
  logic                        setup, wr_en, hit;
  logic [vic_pkg::IDX_W-1:0]   idx;
  logic [31:0]                 rd_val;
  logic                        pready_q, pslverr_q, int_q, wake_q, mbe_q, rbe_q;
  logic [31:0]                 prdata_q;
  logic [2:0]                  vidx_q;
  logic [vic_pkg::VEC_N:1]     vrq_q;
  logic [vic_pkg::START_W-1:0] start_q;

  initial begin
    if (FILTER_STAGES < 2 || FILTER_STAGES > 8) begin
      $error("vic_ctrl filter stages must lie between two and eight");
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Edge inputs.

  // The sampler stops in standby because its clock is held there.
  assign pin0_tick = ~standby & (pin0_sel_q[vic_pkg::SAMPLE_BIT] ? fx_div64_tick : 1'b1); // [RQ10] [RQ12]

  vic_noise_filter #(.STAGES(FILTER_STAGES)) u_pin0_filter ( // [RQ9]
    .clk      (clk),
    .sys_rst  (sys_rst),
    .tick     (pin0_tick),
    .raw      (filtered_ext_pin),
    .filtered (pin0_clean)
  );

  vic_edge_detect u_pin0_edge ( // [RQ7]
    .clk        (clk),
    .sys_rst    (sys_rst),
    .level      (pin0_clean),
    .rise_en    (~pin0_sel_q[vic_pkg::EDGE_BIT]),
    .fall_en    (pin0_sel_q[vic_pkg::EDGE_BIT]),
    .edge_pulse (pin0_evt)
  );

  vic_edge_detect u_pin1_edge ( // [RQ7]
    .clk        (clk),
    .sys_rst    (sys_rst),
    .level      (second_ext_pin),
    .rise_en    (~pin1_sel_q[vic_pkg::EDGE_BIT]),
    .fall_en    (pin1_sel_q[vic_pkg::EDGE_BIT]),
    .edge_pulse (pin1_evt)
  );

  vic_edge_detect u_pin2_edge ( // [RQ8]
    .clk        (clk),
    .sys_rst    (sys_rst),
    .level      (test_ext_pin),
    .rise_en    (1'b1),
    .fall_en    (1'b0),
    .edge_pulse (pin2_evt)
  );

  vic_edge_detect u_pin4_edge ( // [RQ6]
    .clk        (clk),
    .sys_rst    (sys_rst),
    .level      (dual_edge_ext_pin),
    .rise_en    (1'b1),
    .fall_en    (1'b1),
    .edge_pulse (pin4_evt)
  );

  // Set events gathered in flag order.
  always_comb begin
    set_evt                       = '0;
    set_evt[vic_pkg::SRC_BASIC]   = basic_timer_event; // [RQ6]
    set_evt[vic_pkg::SRC_PIN4]    = pin4_evt;
    set_evt[vic_pkg::SRC_PIN0]    = pin0_evt;
    set_evt[vic_pkg::SRC_PIN1]    = pin1_evt;
    set_evt[vic_pkg::SRC_SERIAL]  = serial_done_event;
    set_evt[vic_pkg::SRC_TIMER]   = timer_match_event;
    set_evt[vic_pkg::SRC_PULSE]   = pulse_gen_event;
    set_evt[vic_pkg::SRC_KEYSCAN] = key_scan_event;
    set_evt[vic_pkg::SRC_PIN2]    = pin2_evt;
    set_evt[vic_pkg::SRC_CLOCK]   = clock_timer_event;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // APB slave: a setup cycle followed by one access cycle, no wait states.

  assign setup = psel & ~penable;
  assign idx   = paddr[vic_pkg::ADDR_W-1:2];
  assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;

  // Address decode and read mux.
  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    if (idx == vic_pkg::IDX_PRIO) begin
      rd_val[3:0] = prio_q;
    end else if (idx == vic_pkg::IDX_PIN0) begin
      rd_val[3:0] = pin0_sel_q;
    end else if (idx == vic_pkg::IDX_PIN1) begin
      rd_val[3:0] = pin1_sel_q;
    end else if (idx == vic_pkg::IDX_REQUEST) begin
      rd_val[vic_pkg::SRC_N-1:0] = req_q;
    end else if (idx == vic_pkg::IDX_ENABLE) begin
      rd_val[vic_pkg::SRC_N-1:0] = en_q;
    end else if (idx == vic_pkg::IDX_STATUS) begin
      rd_val[3:0] = {mbe_q, rbe_q, nest_q};
    end else begin
      hit = 1'b0;
    end
  end

  // Ready, error and read data are all prepared in the setup cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~hit;
      if (setup) begin
        prdata_q <= (hit & ~pwrite) ? rd_val : '0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Control registers.

  // Edge select registers start at zero, meaning rising edges.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin0_sel_q <= vic_pkg::CTRL_RST; // [RQ11]
      pin1_sel_q <= vic_pkg::CTRL_RST; // [RQ11]
    end else if (wr_en && idx == vic_pkg::IDX_PIN0) begin
      pin0_sel_q <= pwdata[3:0];
    end else if (wr_en && idx == vic_pkg::IDX_PIN1) begin
      pin1_sel_q <= pwdata[3:0];
    end
  end

  // Enable and disable instructions override a bus write of the master enable.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prio_q <= vic_pkg::CTRL_RST; // [RQ15]
    end else begin
      if (wr_en && idx == vic_pkg::IDX_PRIO) begin
        prio_q <= pwdata[3:0];
      end
      if (enable_instr) begin
        prio_q[vic_pkg::MIE_BIT] <= 1'b1; // [RQ15]
      end else if (disable_instr) begin
        prio_q[vic_pkg::MIE_BIT] <= 1'b0; // [RQ15]
      end
    end
  end

  // Enable flags are software owned.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= vic_pkg::FLAG_RST; // [RQ5]
    end else if (wr_en && idx == vic_pkg::IDX_ENABLE) begin
      en_q <= pwdata[vic_pkg::SRC_N-1:0]; // [RQ1]
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // Request flags, vectors and acceptance.

  assign both_shared = en_q[vic_pkg::SRC_BASIC] & en_q[vic_pkg::SRC_PIN4];

  // Vector request lines; test sources have none.
  always_comb begin
    if (both_shared) begin
      vrq[vic_pkg::VEC_SHARED] = req_q[vic_pkg::SRC_BASIC] & req_q[vic_pkg::SRC_PIN4]; // [RQ21]
    end else begin
      vrq[vic_pkg::VEC_SHARED] = |(req_q[vic_pkg::SRC_PIN4:0] & en_q[vic_pkg::SRC_PIN4:0]); // [RQ20]
    end
    vrq[vic_pkg::VEC_N:2] = req_q[vic_pkg::SRC_KEYSCAN:vic_pkg::SRC_PIN0]
                          & en_q[vic_pkg::SRC_KEYSCAN:vic_pkg::SRC_PIN0]; // [RQ3] [RQ24]
  end

  // Nesting gate and master enable, then fixed priority with vector one first.
  always_comb begin
    high_mask = '0;
    for (int v = 1; v <= vic_pkg::VEC_N; v++) begin
      high_mask[v] = (prio_q[vic_pkg::SEL_W-1:0] == v[vic_pkg::SEL_W-1:0]); // [RQ14]
    end
    case (nest_q)
      vic_pkg::VIC_NEST_NONE: allowed = '1; // [RQ17]
      vic_pkg::VIC_NEST_ONE:  allowed = high_mask; // [RQ17]
      default:                allowed = '0; // [RQ17]
    endcase
    cand     = vrq & allowed & {vic_pkg::VEC_N{prio_q[vic_pkg::MIE_BIT]}}; // [RQ15]
    pend     = |cand;
    pend_idx = '0;
    for (int v = vic_pkg::VEC_N; v >= 1; v--) begin
      if (cand[v]) begin
        pend_idx = v[2:0]; // [RQ23]
      end
    end
  end

  // Flags cleared by acceptance of the registered vector.
  always_comb begin
    clr_acc = '0;
    if (cpu_accept && int_q) begin
      if (vidx_q == vic_pkg::VEC_SHARED[2:0]) begin
        if (!both_shared) begin
          clr_acc[vic_pkg::SRC_PIN4:0] = en_q[vic_pkg::SRC_PIN4:0]; // [RQ20] [RQ21]
        end
      end else begin
        clr_acc[vidx_q] = 1'b1; // [RQ2]
      end
    end
  end

  // A write stores the flags as given; events then win over any clear in the same cycle.
  always_comb begin
    req_d = req_q;
    if (wr_en && idx == vic_pkg::IDX_REQUEST) begin
      req_d = pwdata[vic_pkg::SRC_N-1:0]; // [RQ4]
    end
    req_d = (req_d & ~clr_acc) | set_evt; // [RQ2]
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_q <= vic_pkg::FLAG_RST; // [RQ5]
    end else begin
      req_q <= req_d; // [RQ1]
    end
  end

  // Nesting status: acceptance steps up, return restores, software may rewrite it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nest_q <= vic_pkg::VIC_NEST_NONE;
    end else if (cpu_accept && int_q) begin
      nest_q <= (nest_q == vic_pkg::VIC_NEST_NONE) ? vic_pkg::VIC_NEST_ONE
                                                   : vic_pkg::VIC_NEST_TWO; // [RQ18]
    end else if (return_from_interrupt) begin
      nest_q <= restore_status; // [RQ18]
    end else if (wr_en && idx == vic_pkg::IDX_STATUS) begin
      nest_q <= pwdata[1:0]; // [RQ19]
    end
  end

  // Vector word fields are captured as the service routine is entered.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_q <= '0;
      mbe_q   <= 1'b0;
      rbe_q   <= 1'b0;
    end else if (cpu_accept && int_q) begin
      start_q <= vector_word[vic_pkg::START_W-1:0]; // [RQ22]
      mbe_q   <= vector_word[vic_pkg::VW_MBE_BIT]; // [RQ22]
      rbe_q   <= vector_word[vic_pkg::VW_RBE_BIT]; // [RQ22]
    end
  end

  // Request toward the core drops for the cycle after an accept so a stale vector is never taken twice.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_q  <= 1'b0;
      vidx_q <= '0;
      vrq_q  <= '0;
      wake_q <= 1'b0;
    end else begin
      int_q  <= pend & ~(cpu_accept & int_q);
      vidx_q <= pend_idx;
      vrq_q  <= vrq; // [RQ3]
      wake_q <= |(req_q & en_q); // [RQ3]
    end
  end

  assign prdata                = prdata_q;
  assign pready                = pready_q;
  assign pslverr               = pslverr_q;
  assign int_request           = int_q;
  assign vector_index          = vidx_q;
  assign vector_addr           = {{(vic_pkg::ADDR_W-4){1'b0}}, vidx_q, 1'b0};
  assign vectored_request_line = vrq_q;
  assign standby_wake          = wake_q;
  assign nest_status           = nest_q;
  assign service_start         = start_q;
  assign memory_bank_enable    = mbe_q;
  assign register_bank_enable  = rbe_q;

  //////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_accept(int v);
    cpu_accept && int_q && vidx_q == v;
  endsequence

  a_accept_clears: assert property (s_accept(3) ##0 (!pin1_evt && !wr_en) |=> !req_q[vic_pkg::SRC_PIN1]) else $error("accepted flag not cleared"); // [RQ2]
  a_shared_kept: assert property (s_accept(1) ##0 (both_shared && !wr_en) |=> !$past(req_q[vic_pkg::SRC_BASIC]) || req_q[vic_pkg::SRC_BASIC]) else $error("shared flag cleared"); // [RQ21]
  a_nest_step: assert property (s_accept(vidx_q) ##0 nest_q == 2'b00 |=> nest_q == 2'b01) else $error("nest status did not advance"); // [RQ17]
  a_nest_blocks: assert property (nest_q == 2'b10 [*2] |-> !int_q) else $error("request in full nesting"); // [RQ17]
  a_master_gate: assert property (!prio_q[vic_pkg::MIE_BIT] [*2] |-> !int_q) else $error("request while masked"); // [RQ15]
  a_test_novec: assert property (int_q |-> vidx_q >= 1 && vidx_q <= vic_pkg::VEC_N && vrq_q[vidx_q]) else $error("bad vector index"); // [RQ24]
  a_ei_sets: assert property (enable_instr |=> prio_q[vic_pkg::MIE_BIT]) else $error("enable did not set master"); // [RQ15]
  a_pin2_rise: assert property (test_ext_pin && !$past(test_ext_pin) ##1 1 |-> req_q[vic_pkg::SRC_PIN2]) else $error("pin two edge lost"); // [RQ8]
  a_vrq_line: assert property (req_q[vic_pkg::SRC_TIMER] && en_q[vic_pkg::SRC_TIMER] |=> vrq_q[5]) else $error("vector line missing"); // [RQ3]
  a_sw_set: assert property (wr_en && idx == vic_pkg::IDX_REQUEST && pwdata[vic_pkg::SRC_SERIAL] |=> req_q[vic_pkg::SRC_SERIAL]) else $error("software set lost"); // [RQ4]
  a_prio_low: assert property (pend && cand[vic_pkg::VEC_SHARED] && !(cpu_accept && int_q) |=> int_q && vidx_q == 1) else $error("priority order wrong"); // [RQ23]

endmodule // vic_ctrl

// *** vic_pkg.sv ***
// Constants shared by the vectored interrupt controller and its helpers.
package vic_pkg;

  // Request and enable vector layout, one bit per source.
  localparam int SRC_N         = 10;
  localparam int SRC_BASIC     = 0;
  localparam int SRC_PIN4      = 1;
  localparam int SRC_PIN0      = 2;
  localparam int SRC_PIN1      = 3;
  localparam int SRC_SERIAL    = 4;
  localparam int SRC_TIMER     = 5;
  localparam int SRC_PULSE     = 6;
  localparam int SRC_KEYSCAN   = 7;
  localparam int SRC_PIN2      = 8;
  localparam int SRC_CLOCK     = 9;

  // Vectored request numbering: vector 1 is the shared one, 7 the lowest priority.
  localparam int VEC_N         = 7;
  localparam int VEC_SHARED    = 1;

  // Register indices; the byte address is four times the index.
  localparam int IDX_W                      = 14;
  localparam logic [IDX_W-1:0] IDX_PRIO     = 14'h0FB2;
  localparam logic [IDX_W-1:0] IDX_PIN0     = 14'h0FB4;
  localparam logic [IDX_W-1:0] IDX_PIN1     = 14'h0FB5;
  localparam logic [IDX_W-1:0] IDX_REQUEST  = 14'h0FB8;
  localparam logic [IDX_W-1:0] IDX_ENABLE   = 14'h0FB9;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 14'h0FBA;
  localparam int ADDR_W        = 16;

  // Field positions inside the four-bit control registers.
  localparam int EDGE_BIT      = 0;
  localparam int SAMPLE_BIT    = 3;
  localparam int MIE_BIT       = 3;
  localparam int SEL_W         = 3;

  // Reset values.
  localparam logic [3:0]       CTRL_RST  = 4'h0;
  localparam logic [SRC_N-1:0] FLAG_RST  = 10'h000;

  // Vector word layout: bank flags on top, service start address below.
  localparam int VW_W          = 16;
  localparam int VW_MBE_BIT    = 15;
  localparam int VW_RBE_BIT    = 14;
  localparam int START_W       = 14;

  // Nesting status codes, one-hot except NONE, which is all zeros.
  typedef enum logic [1:0] {
    VIC_NEST_NONE = 2'b00,
    VIC_NEST_ONE  = 2'b01,
    VIC_NEST_TWO  = 2'b10
  } vic_nest_t;

endpackage

// *** vic_edge_detect.sv ***
// Edge detector with separately enabled rising and falling edges.
`timescale 1ns/1ps
module vic_edge_detect (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic level,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      edge_pulse
);

  logic prev_q;

  // Previous level; starting low means a pin held high at reset reads as one rising edge.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  // One-cycle pulse on any enabled transition.
  assign edge_pulse = (rise_en & level & ~prev_q) | (fall_en & ~level & prev_q);

endmodule // vic_edge_detect

// *** vic_noise_filter.sv ***
// Sampled noise filter: the output follows only levels seen on consecutive ticks.
`timescale 1ns/1ps
module vic_noise_filter #(
  parameter int STAGES = 2
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic tick,
  input  wire logic raw,
  output logic      filtered
);

  logic [STAGES-1:0] samp_q;
  logic              filt_q;

  initial begin
    if (STAGES < 2) begin
      $error("vic_noise_filter needs at least two sample stages");
    end
  end

  // Samples are taken only on ticks, so a pulse shorter than one tick period may vanish.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_q <= '0;
    end else if (tick) begin
      samp_q <= {samp_q[STAGES-2:0], raw};
    end
  end

  // The level changes only when all stored samples agree.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_q <= 1'b0;
    end else if (&samp_q) begin
      filt_q <= 1'b1;
    end else if (~|samp_q) begin
      filt_q <= 1'b0;
    end
  end

  assign filtered = filt_q;

endmodule // vic_noise_filter

// *** vic_cpu_model.sv ***
// Behavioural model of the CPU core that takes vectors from the interrupt controller.
`timescale 1ns/1ps
module vic_cpu_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        go,
  input  wire logic        int_request,
  input  wire logic [2:0]  vector_index,
  output logic             cpu_accept,
  output logic [15:0]      vector_word
);
  logic take;

  // The core takes a vector only while the bench allows it, one pulse at a time.
  assign take = go & int_request & ~cpu_accept;

  // The accept is one cycle wide, so the request line can fall before the next one.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_accept  <= 1'b0;
      vector_word <= 16'h0000;
    end else begin
      cpu_accept  <= take;
      // Bank flags and start address travel with the accept; the word toggles otherwise.
      vector_word <= take ? {2'b10, 11'h000, vector_index} : ~vector_word;
    end
  end
endmodule // vic_cpu_model

// *** vic_ctrl_tb.sv ***
// Self-checking testbench for the vectored interrupt controller.
`timescale 1ns/1ps
module vic_ctrl_tb;
  logic        clk = 1'b0, sys_rst = 1'b1, go = 1'b0, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [15:0] paddr = 16'h0000, vector_word, vector_addr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        filtered_ext_pin = 1'b0, second_ext_pin = 1'b0, test_ext_pin = 1'b0;
  logic        dual_edge_ext_pin = 1'b0, fx_div64_tick = 1'b0, standby = 1'b0;
  logic        basic_timer_event = 1'b0, serial_done_event = 1'b0, timer_match_event = 1'b0;
  logic        pulse_gen_event = 1'b0, key_scan_event = 1'b0, clock_timer_event = 1'b0;
  logic        enable_instr = 1'b0, disable_instr = 1'b0, cpu_accept;
  logic        return_from_interrupt = 1'b0, int_request, standby_wake;
  logic [1:0]  restore_status = 2'b00, nest_status;
  logic [2:0]  vector_index;
  logic [7:1]  vectored_request_line;
  logic [13:0] service_start;
  logic        memory_bank_enable, register_bank_enable;
  int          num_errors = 0, num_checks = 0, cyc = 0;

  vic_ctrl #(.FILTER_STAGES(2)) dut (.*);
  vic_cpu_model cpu (.*);

  // 200 MHz clock.
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request holds until pready is seen high at an edge.
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Waits, with no bound of its own, for the nesting status to reach a value; a hang is left to the timeout.
  task automatic wait_nest(input logic [1:0] v);
    while (nest_status !== v) @(posedge clk);
  endtask

  task automatic wait_req();
    while (int_request !== 1'b1) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values of every register but the status, and a refused access to an unmapped word.
  task automatic t_reset_values();
    apb(1'b0, vic_pkg::IDX_PRIO, 32'h0);    chk(rd, 32'h0);
    apb(1'b0, vic_pkg::IDX_PIN0, 32'h0);    chk(rd, 32'h0);
    apb(1'b0, vic_pkg::IDX_PIN1, 32'h0);    chk(rd, 32'h0);
    apb(1'b0, vic_pkg::IDX_REQUEST, 32'h0); chk(rd, 32'h0);
    apb(1'b0, vic_pkg::IDX_ENABLE, 32'h0);  chk(rd, 32'h0);
    apb(1'b0, 14'h0FBF, 32'h0);             chk(err, 1'b1);
  endtask

  // Test sources wake the part but never raise a vectored request.
  task automatic t_test_sources();
    apb(1'b1, vic_pkg::IDX_ENABLE, 32'h3FF);
    apb(1'b1, vic_pkg::IDX_PRIO, 32'h8);
    apb(1'b1, vic_pkg::IDX_REQUEST, 32'h300);
    repeat (4) @(posedge clk);
    chk(int_request, 1'b0);
    chk(standby_wake, 1'b1);
    apb(1'b1, vic_pkg::IDX_REQUEST, 32'h0);
  endtask

  // A timer match raises vector five; acceptance clears its flag and steps the status.
  task automatic t_timer_accept();
    timer_match_event <= 1'b1;
    @(posedge clk);
    timer_match_event <= 1'b0;
    wait_req();
    chk(vector_index, 3'h5);
    chk(vector_addr, 16'h000A);
    chk(vectored_request_line, 7'h10);
    go <= 1'b1;
    wait_nest(2'b01);
    go <= 1'b0;
    @(posedge clk);
    chk(memory_bank_enable, 1'b1);
    chk(register_bank_enable, 1'b0);
    chk(service_start, 14'h0005);
    apb(1'b0, vic_pkg::IDX_REQUEST, 32'h0);
    chk(rd, 32'h0);
  endtask

  // At status one only the high-order source gets in; a software-set flag interrupts too.
  task automatic t_nesting();
    apb(1'b1, vic_pkg::IDX_REQUEST, 32'h20);
    repeat (4) @(posedge clk);
    chk(int_request, 1'b0);
    apb(1'b1, vic_pkg::IDX_PRIO, 32'h5);
    enable_instr <= 1'b1;
    @(posedge clk);
    enable_instr <= 1'b0;
    wait_req();
    chk(vector_index, 3'h5);
    go <= 1'b1;
    wait_nest(2'b10);
    go <= 1'b0;
    chk(nest_status, 2'b10);
  endtask

  // Pin one on falling edges after a guarded mode change, then both shared sources at once.
  task automatic t_edge_shared();
    disable_instr <= 1'b1;
    @(posedge clk);
    disable_instr <= 1'b0;
    apb(1'b1, vic_pkg::IDX_PIN1, 32'h1);
    apb(1'b1, vic_pkg::IDX_REQUEST, 32'h0);
    apb(1'b1, vic_pkg::IDX_STATUS, 32'h0);
    chk(nest_status, 2'b00);
    second_ext_pin <= 1'b1;
    @(posedge clk);
    second_ext_pin <= 1'b0;
    repeat (2) @(posedge clk);
    apb(1'b0, vic_pkg::IDX_REQUEST, 32'h0);
    chk(rd, 32'h8);
    apb(1'b1, vic_pkg::IDX_REQUEST, 32'h3);
    enable_instr <= 1'b1;
    @(posedge clk);
    enable_instr <= 1'b0;
    wait_req();
    chk(vector_index, 3'h1);
    go <= 1'b1;
    wait_nest(2'b01);
    go <= 1'b0;
    apb(1'b0, vic_pkg::IDX_REQUEST, 32'h0);
    chk(rd, 32'h3);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // A hang counts as a mismatch and goes straight to the verdict.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end

  // Main sequence: reset for six cycles, then the scenarios in order.
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset_values();
    t_test_sources();
    t_timer_accept();
    t_nesting();
    t_edge_shared();
    summarize();
  end
endmodule // vic_ctrl_tb
